// File: hw/output_fault_pc_rewind.sv
// Output-fault program counter rewind sequencer with its register port.
// Assumes the first instruction sequence pulses hold_set at T3.4, and
// that all inputs are synchronous to clk_sys.
//
// Functional notes
// - Set the decrement flag at T1.4 only while hold one and the resume fault are both set.
// - Set the borrow insert flag at T1.4 while the decrement is under way.
// - Load X with all ones through both select strobes at T1.4.
// - At T2.2 set the hold release flag and, under hold and decrement, the update gate.
// - At T2.3 clear the borrow insert flag and clear D through the advance path.
// - At T2.4 set the borrow insert flag again and copy both halves of P into D.
// - At T3.1 clear the decrement flag with the same gating term that set it.
// - At T3.2 clear P and load it from the adder as in an ordinary update.
// - At T3.3 clear the update gate once increment and decrement flags are clear.
// - At T4.3 clear the borrow insert flag and the hold release flag.
// - Both holds suppress sequence control; hold one ends at T4.2, hold two at T1.3 next.
// - The interrupt sequence flag clears at T2.1, then sets with interrupt active at T2.2.
// - The interrupt only honours the resume fault when no higher request is pending.
// - The adder computes X minus complemented D with X all ones, and the borrow gives D minus one.
// - An unaccomplished output with an honoured fault rewinds P to the same instruction.
// - A resume fault arises when resume stays clear too long in intercomputer mode.
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rewind_consts.svh"

module output_fault_pc_rewind
  import rewind_pkg::*;
#(
  parameter int W = 16,
  parameter int RESUME_LIMIT = 1000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic hold_set,
  input wire logic resume_flag,
  input wire logic counter_increment_flag,
  input wire logic higher_prio,
  input wire logic int_done,
  output logic seq_suppress,
  output logic int_seq,
  output logic int_active,
  output logic [W-1:0] pc_value
);

  localparam int CW = $clog2(RESUME_LIMIT + 1);

  seq_if #(.W(W)) sif ();

  slot_timer u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .tm(sif)
  );

  pc_datapath #(.W(W)) u_dp (
    .clk_sys(clk_sys),
    .rst(rst),
    .dp(sif)
  );

  //////////////////////////////////////////////////////////////////////////
  // Flags and state.

  seq_state_t state_r;
  seq_state_t state_nxt;
  logic hold1_r;
  logic hold2_r;
  logic counter_decrement_flag;
  logic borrow_insert_flag;
  logic counter_update_gate_flag;
  logic hold_release_flag;
  logic resume_fault_r;
  logic [CW-1:0] resume_cnt_r;
  logic ctrl_icm_r;
  logic [`EV_W-1:0] status_r;
  logic [`EV_W-1:0] mask_r;
  logic int_seq_r;
  logic int_active_r;
  logic irq_r;
  logic seq_suppress_r;
  logic [31:0] rdata_r;

  //////////////////////////////////////////////////////////////////////////
  // Tick decode; each strobed command acts on its own phase of its slot.

  wire t13 = at_tick(sif.slot, sif.phase, `SLOT_T1, `PH_3);
  wire t14 = at_tick(sif.slot, sif.phase, `SLOT_T1, `PH_4);
  wire t21 = at_tick(sif.slot, sif.phase, `SLOT_T2, `PH_1);
  wire t22 = at_tick(sif.slot, sif.phase, `SLOT_T2, `PH_2);
  wire t23 = at_tick(sif.slot, sif.phase, `SLOT_T2, `PH_3);
  wire t24 = at_tick(sif.slot, sif.phase, `SLOT_T2, `PH_4);
  wire t31 = at_tick(sif.slot, sif.phase, `SLOT_T3, `PH_1);
  wire t32 = at_tick(sif.slot, sif.phase, `SLOT_T3, `PH_2);
  wire t33 = at_tick(sif.slot, sif.phase, `SLOT_T3, `PH_3);
  wire t34 = at_tick(sif.slot, sif.phase, `SLOT_T3, `PH_4);
  wire t42 = at_tick(sif.slot, sif.phase, `SLOT_T4, `PH_2);
  wire t43 = at_tick(sif.slot, sif.phase, `SLOT_T4, `PH_3);

  // One gating term both sets and clears the decrement flag.
  wire in_held = (state_r == ST_HELD);
  wire in_handoff = (state_r == ST_HANDOFF);
  wire decr_gate = in_held && hold1_r && resume_fault_r;
  wire first_seq_done = t34 && hold_set && (state_r == ST_IDLE);
  wire honour = t22 && in_handoff && resume_fault_r && !higher_prio;

  //////////////////////////////////////////////////////////////////////////
  // Register port decode.

  wire sel_ctrl = (addr == `OFF_CTRL);
  wire sel_status = (addr == `OFF_STATUS);
  wire sel_mask = (addr == `OFF_MASK);
  wire sel_pc = (addr == `OFF_PC);
  wire sel_flags = (addr == `OFF_FLAGS);
  wire status_rd = rd_en && sel_status;
  wire [31:0] flags_w = 32'(
    {resume_fault_r, int_active_r, int_seq_r, hold_release_flag,
     counter_update_gate_flag, borrow_insert_flag,
     counter_decrement_flag, hold2_r, hold1_r});
  wire [31:0] rd_mux =
    sel_ctrl ? 32'(ctrl_icm_r) :
    sel_status ? 32'(status_r) :
    sel_mask ? 32'(mask_r) :
    sel_pc ? 32'(sif.p_value) :
    sel_flags ? flags_w : 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////
  // Datapath commands; all but borrow (the flag level) and pc_wr are one-cycle strobes on their ticks.

  assign sif.load_x_ones = t14 && decr_gate;
  assign sif.clear_d = t23 && counter_decrement_flag;
  assign sif.copy_p = t24 && counter_decrement_flag;
  assign sif.load_p = t32 && counter_update_gate_flag;
  assign sif.borrow = borrow_insert_flag;
  assign sif.pc_wr = wr_en && sel_pc;
  assign sif.pc_wdata = wdata[W-1:0];

  //////////////////////////////////////////////////////////////////////////
  // Sequence state: held frame, then the interrupt hand-off frame.

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (first_seq_done) state_nxt = ST_HELD;
      ST_HELD: if (t42 && hold_release_flag) state_nxt = ST_HANDOFF;
      ST_HANDOFF: if (t22) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  // Hold flags keep normal sequence control off through the held frame.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold1_r <= 1'b0;
      hold2_r <= 1'b0;
    end else begin
      if (first_seq_done) hold1_r <= 1'b1;
      else if (t42 && hold_release_flag) hold1_r <= 1'b0;
      if (first_seq_done) hold2_r <= 1'b1;
      else if (t13 && in_handoff && !hold1_r) hold2_r <= 1'b0;
    end
  end

  // Decrement, borrow insert, update gate and hold release flags.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      counter_decrement_flag <= 1'b0;
      borrow_insert_flag <= 1'b0;
      counter_update_gate_flag <= 1'b0;
      hold_release_flag <= 1'b0;
    end else begin
      if (t14 && decr_gate) counter_decrement_flag <= 1'b1;
      else if (t31 && decr_gate) counter_decrement_flag <= 1'b0;
      if (t14 && decr_gate) borrow_insert_flag <= 1'b1;
      else if (t23 && in_held) borrow_insert_flag <= 1'b0;
      else if (t24 && counter_decrement_flag)
        borrow_insert_flag <= 1'b1;
      else if (t43 && in_handoff) borrow_insert_flag <= 1'b0;
      if (t22 && hold1_r && counter_decrement_flag)
        counter_update_gate_flag <= 1'b1;
      else if (t33 && !counter_increment_flag && !counter_decrement_flag)
        counter_update_gate_flag <= 1'b0;
      if (t22 && in_held) hold_release_flag <= 1'b1;
      else if (t43 && !hold1_r) hold_release_flag <= 1'b0;
    end
  end

  // Resume watchdog: only intercomputer mode leaves resume clear for long.
  // A fault that arrives as it is honoured stays set, so none is lost.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resume_cnt_r <= '0;
      resume_fault_r <= 1'b0;
    end else begin
      if (resume_flag || !ctrl_icm_r) resume_cnt_r <= '0;
      else if (resume_cnt_r != CW'(RESUME_LIMIT))
        resume_cnt_r <= resume_cnt_r + CW'(1);
      if (resume_cnt_r == CW'(RESUME_LIMIT - 1) && !resume_flag
          && ctrl_icm_r)
        resume_fault_r <= 1'b1;
      else if (honour) resume_fault_r <= 1'b0;
    end
  end

  // Interrupt sequence runs beside the next instruction sequence.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_seq_r <= 1'b0;
      int_active_r <= 1'b0;
    end else begin
      if (honour) begin
        int_seq_r <= 1'b1;
        int_active_r <= 1'b1;
      end else if (t21 && in_handoff) begin
        int_seq_r <= 1'b0;
      end else if (int_done) begin
        int_seq_r <= 1'b0;
        int_active_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Software registers, sticky events and the interrupt output.

  wire [`EV_W-1:0] events_w = {honour,
    (resume_cnt_r == CW'(RESUME_LIMIT - 1)) && !resume_flag && ctrl_icm_r,
    sif.load_p};
  // An event in the cycle of a status read survives the read's clear.
  wire [`EV_W-1:0] status_nxt =
    (status_rd ? `EV_RST : status_r) | events_w;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_icm_r <= `CTRL_RST;
      mask_r <= `EV_RST;
      status_r <= `EV_RST;
      irq_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      seq_suppress_r <= 1'b0;
    end else begin
      if (wr_en && sel_ctrl) ctrl_icm_r <= wdata[`CTRL_ICM];
      if (wr_en && sel_mask) mask_r <= wdata[`EV_W-1:0];
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_r);
      rdata_r <= rd_en ? rd_mux : 32'h0000_0000;
      seq_suppress_r <= hold1_r || hold2_r;
    end
  end

  assign rdata = rdata_r;
  assign irq = irq_r;
  assign seq_suppress = seq_suppress_r;
  assign int_seq = int_seq_r;
  assign int_active = int_active_r;
  assign pc_value = sif.p_value;

  //////////////////////////////////////////////////////////////////////////
  // Checks on the held sequence.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_rewind_start;
    t14 && decr_gate;
  endsequence

  sequence s_decr_window;
    counter_decrement_flag [*5];
  endsequence

  property p_decr_set;
    s_rewind_start |=> s_decr_window ##1 !counter_decrement_flag;
  endproperty
  a_decr_set: assert property (p_decr_set)
    else $error("Decrement flag did not span T1.4 to T3.1.");

  property p_borrow_set;
    s_rewind_start |=> borrow_insert_flag [*3];
  endproperty
  a_borrow_set: assert property (p_borrow_set)
    else $error("Borrow insert flag not held from T1.4 to T2.3.");

  property p_gate_set;
    (t22 && hold1_r && counter_decrement_flag)
      |=> counter_update_gate_flag && hold_release_flag;
  endproperty
  a_gate_set: assert property (p_gate_set)
    else $error("Update gate or release not set at T2.2.");

  property p_borrow_drop;
    (t23 && in_held && counter_decrement_flag)
      |=> !borrow_insert_flag ##1 borrow_insert_flag;
  endproperty
  a_borrow_drop: assert property (p_borrow_drop)
    else $error("Borrow not dropped at T2.3 and reset at T2.4.");

  property p_pc_update;
    s_rewind_start |-> ##10 (pc_value == $past(pc_value, 10) - W'(1));
  endproperty
  a_pc_update: assert property (p_pc_update)
    else $error("Program counter not rewound by one after T3.2.");

  property p_gate_clear;
    (t33 && !counter_increment_flag && !counter_decrement_flag)
      |=> !counter_update_gate_flag;
  endproperty
  a_gate_clear: assert property (p_gate_clear)
    else $error("Update gate not cleared at T3.3.");

  property p_end_held;
    (t43 && in_handoff && !hold1_r) |=> !borrow_insert_flag
      && !hold_release_flag;
  endproperty
  a_end_held: assert property (p_end_held)
    else $error("Held sequence flags not cleared at T4.3.");

  property p_hold2_release;
    (t13 && in_handoff) |=> !hold2_r ##[1:2] !seq_suppress;
  endproperty
  a_hold2_release: assert property (p_hold2_release)
    else $error("Hold two not released at T1.3.");

  property p_int_start;
    (t22 && in_handoff && resume_fault_r && !higher_prio)
      |=> int_seq_r && int_active_r ##[1:3] status_r[`EV_INT];
  endproperty
  a_int_start: assert property (p_int_start)
    else $error("Interrupt sequence not started at T2.2.");

  property p_int_defer;
    (t22 && higher_prio && !int_seq_r) |=> !int_seq_r;
  endproperty
  a_int_defer: assert property (p_int_defer)
    else $error("Resume fault honoured over a higher request.");

endmodule

`default_nettype wire

// File: hw/rewind_consts.svh
// Constants for the output-fault program counter rewind block.
// Assumes inclusion by bare name from files that need offsets or fields.
`ifndef REWIND_CONSTS_SVH
`define REWIND_CONSTS_SVH

// Register byte offsets on the plain register port.
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_MASK 8'h08
`define OFF_PC 8'h0C
`define OFF_FLAGS 8'h10

// Control register fields and reset value.
`define CTRL_ICM 0
`define CTRL_RST 1'h0

// Event bits shared by the status and mask registers.
`define EV_W 3
`define EV_REWOUND 0
`define EV_FAULT 1
`define EV_INT 2
`define EV_RST 3'h0

// Flag register field positions.
`define FL_HOLD1 0
`define FL_HOLD2 1
`define FL_DECR 2
`define FL_BORROW 3
`define FL_GATE 4
`define FL_RELEASE 5
`define FL_INTSEQ 6
`define FL_INTACT 7
`define FL_FAULT 8

// Time slot and phase codes.
`define SLOT_T1 2'h0
`define SLOT_T2 2'h1
`define SLOT_T3 2'h2
`define SLOT_T4 2'h3
`define PH_1 2'h0
`define PH_2 2'h1
`define PH_3 2'h2
`define PH_4 2'h3
`define PH_LAST 2'h3

`endif

// File: hw/rewind_pkg.sv
// Types and helpers for the output-fault program counter rewind block.
// Assumes nothing beyond a SystemVerilog compiler.
package rewind_pkg;

  typedef logic [1:0] slot_t;
  typedef logic [1:0] phase_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HELD = 2'b01,
    ST_HANDOFF = 2'b10
  } seq_state_t;

  // True in the cycle whose slot and phase match the named tick.
  function automatic logic at_tick(slot_t s, phase_t p, slot_t ts,
                                   phase_t tp);
    return (s == ts) && (p == tp);
  endfunction

endpackage

// File: hw/seq_if.sv
// Interface between the sequencer, the slot timer and the counter datapath.
// Assumes all three parties run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface seq_if #(parameter int W = 16);
  logic [1:0] slot;
  logic [1:0] phase;
  logic load_x_ones;
  logic clear_d;
  logic copy_p;
  logic load_p;
  logic borrow;
  logic pc_wr;
  logic [W-1:0] pc_wdata;
  logic [W-1:0] p_value;

  modport timer (output slot, output phase);
  modport dp (input load_x_ones, input clear_d, input copy_p, input load_p,
              input borrow, input pc_wr, input pc_wdata, output p_value);
  modport ctrl (input slot, input phase, input p_value,
                output load_x_ones, output clear_d, output copy_p,
                output load_p, output borrow, output pc_wr,
                output pc_wdata);
endinterface

`default_nettype wire

// File: hw/slot_timer.sv
// Slot timer: four time slots, each of four clock phases.
// Assumes one phase per clock cycle and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module slot_timer
  import rewind_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  seq_if.timer tm
);

  slot_t slot_r;
  phase_t phase_r;

  // Phase runs every cycle; the slot steps after the last phase.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      slot_r <= `SLOT_T1;
      phase_r <= `PH_1;
    end else begin
      phase_r <= phase_r + 2'h1;
      if (phase_r == `PH_LAST) slot_r <= slot_r + 2'h1;
    end
  end

  assign tm.slot = slot_r;
  assign tm.phase = phase_r;

endmodule

`default_nettype wire

// File: hw/pc_datapath.sv
// Program counter datapath: P, D and X registers and the X - D' adder.
// Assumes commands arrive as one-cycle strobes from the sequencer, except borrow, which is a level.
`timescale 1ns/1ps
`default_nettype none

module pc_datapath #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  seq_if.dp dp
);

  logic [W-1:0] p_r;
  logic [W-1:0] d_r;
  logic [W-1:0] x_r;
  logic [W-1:0] adder_w;

  // Ones-complement style subtract with an inserted borrow; X all ones
  // makes X - D' equal D, so the borrow alone yields D - 1.
  assign adder_w = x_r - (~d_r) - W'(dp.borrow);
  assign dp.p_value = p_r;

  // P takes software loads first, then the adder on a counter update.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      p_r <= '0;
    end else if (dp.pc_wr) begin
      p_r <= dp.pc_wdata;
    end else if (dp.load_p) begin
      p_r <= adder_w;
    end
  end

  // D is cleared before the copy so stale bits cannot leak into it.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      d_r <= '0;
    end else if (dp.clear_d) begin
      d_r <= '0;
    end else if (dp.copy_p) begin
      d_r <= p_r;
    end
  end

  // X gets all ones from the arithmetic selector, both strobes at once.
  always_ff @(posedge clk_sys) begin
    if (rst) x_r <= '0;
    else if (dp.load_x_ones) x_r <= '1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_x_ones;
    dp.load_x_ones |=> (x_r == '1);
  endproperty
  a_x_ones: assert property (p_x_ones)
    else $error("X not all ones after select strobes.");

  property p_pc_dec;
    (dp.load_p && !dp.pc_wr && dp.borrow && x_r == '1)
      |=> (p_r == $past(d_r) - W'(1));
  endproperty
  a_pc_dec: assert property (p_pc_dec)
    else $error("Counter update did not yield D minus one.");

endmodule

`default_nettype wire

// File: tb/output_fault_pc_rewind_tb.sv
// Self-checking bench for the output-fault counter rewind sequencer.
// Assumes the design files under hw/ are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "rewind_consts.svh"

module output_fault_pc_rewind_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic hold_set = 1'b0;
  logic resume_flag = 1'b1;
  logic counter_increment_flag = 1'b0;
  logic higher_prio = 1'b0;
  logic int_done = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic seq_suppress;
  logic int_seq;
  logic int_active;
  logic [15:0] pc_value;
  logic [3:0] k;
  logic [31:0] v;
  int miscompares = 0;
  int n_checks = 0;

  output_fault_pc_rewind #(.W(16), .RESUME_LIMIT(8)) dut (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
    .hold_set(hold_set), .resume_flag(resume_flag),
    .counter_increment_flag(counter_increment_flag),
    .higher_prio(higher_prio), .int_done(int_done),
    .seq_suppress(seq_suppress), .int_seq(int_seq),
    .int_active(int_active), .pc_value(pc_value)
  );

  // Clock of 20 ns period.
  always #10 clk_sys = ~clk_sys;

  // Own copy of slot and phase: slot in the high two bits of k.
  always @(posedge clk_sys) begin
    if (rst) begin
      k <= 4'h0;
    end else begin
      k <= k + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks for reporting, bus cycles and frame alignment.
  task automatic wrap_up();
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits to the falling edge inside tick t; a lost frame ends the run.
  task automatic sync(input logic [3:0] t);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      if (k === t) return;
    end
    miscompares++;
    wrap_up();
  endtask

  // A gap cycle after each strobe keeps one assignment per time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    d = rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Pulses hold_set for exactly the cycle of tick t.
  task automatic pulse_hold(input logic [3:0] t);
    sync(t - 4'h1);
    @(posedge clk_sys);
    hold_set <= 1'b1;
    @(posedge clk_sys);
    hold_set <= 1'b0;
  endtask

  // Resume held clear well past the shortened limit of 8 cycles.
  task automatic drop_resume();
    @(posedge clk_sys);
    resume_flag <= 1'b0;
    repeat (12) @(posedge clk_sys);
    resume_flag <= 1'b1;
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs();
    rdc(`OFF_CTRL, 32'h0);
    rdc(`OFF_STATUS, 32'h0);
    rdc(`OFF_PC, 32'h0);
    rdc(`OFF_FLAGS, 32'h0);
    wr(`OFF_MASK, 32'hFF);
    rdc(`OFF_MASK, 32'h7);
    wr(`OFF_FLAGS, 32'hFF);
    rdc(`OFF_FLAGS, 32'h0);
    wr(8'h20, 32'hFF);
    rdc(8'h20, 32'h0);
    wr(`OFF_MASK, 32'h0);
  endtask

  // Without intercomputer mode no fault arises, so the block only holds.
  task automatic t_no_fault();
    wr(`OFF_PC, 32'h42);
    drop_resume();
    rdc(`OFF_FLAGS, 32'h0);
    pulse_hold(4'hA);
    rdc(`OFF_FLAGS, 32'h0);
    pulse_hold(4'hB);
    sync(4'h3);
    rdc(`OFF_FLAGS, 32'h3);
    chk({31'h0, seq_suppress}, 32'h1);
    sync(4'hA);
    chk({16'h0, pc_value}, 32'h42);
    do_reset();
  endtask

  // Full rewind with the interrupt honoured afterwards.
  task automatic t_rewind();
    wr(`OFF_PC, 32'h1234);
    wr(`OFF_CTRL, 32'h1);
    drop_resume();
    rdc(`OFF_FLAGS, 32'h100);
    chk({31'h0, irq}, 32'h0);
    wr(`OFF_MASK, 32'h7);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    pulse_hold(4'hB);
    sync(4'h3);
    rdc(`OFF_FLAGS, 32'h10F);
    sync(4'hA);
    chk({16'h0, pc_value}, 32'h1233);
    rdc(`OFF_FLAGS, 32'h12B);
    sync(4'hF);
    rdc(`OFF_FLAGS, 32'h102);
    sync(4'h5);
    rdc(`OFF_FLAGS, 32'hC0);
    chk({30'h0, int_seq, int_active}, 32'h3);
    chk({31'h0, seq_suppress}, 32'h0);
    rdc(`OFF_STATUS, 32'h7);
    rdc(`OFF_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk_sys);
    int_done <= 1'b1;
    @(posedge clk_sys);
    int_done <= 1'b0;
    @(negedge clk_sys);
    chk({30'h0, int_seq, int_active}, 32'h0);
  endtask

  // Increment busy keeps the gate; a higher request blocks the interrupt.
  task automatic t_blocked();
    wr(`OFF_PC, 32'h100);
    @(posedge clk_sys);
    counter_increment_flag <= 1'b1;
    higher_prio <= 1'b1;
    drop_resume();
    pulse_hold(4'hB);
    sync(4'hA);
    chk({16'h0, pc_value}, 32'hFF);
    rdc(`OFF_FLAGS, 32'h13B);
    sync(4'h5);
    chk({30'h0, int_seq, int_active}, 32'h0);
    rd(`OFF_FLAGS, v);
    chk(v & 32'h100, 32'h100);
    do_reset();
    @(negedge clk_sys);
    chk({15'h0, irq, pc_value}, 32'h0);
    rdc(`OFF_FLAGS, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_no_fault();
    t_rewind();
    t_blocked();
    wrap_up();
  end
endmodule

`default_nettype wire
